// file: tm16_pkg.sv
package tm16_pkg;

  // register addresses
  localparam logic [7:0] ADDR_MODE_CTRL = 8'h80;
  localparam logic [7:0] ADDR_CTRL_SECOND = 8'h81;
  localparam logic [7:0] ADDR_PIN_EN = 8'h83;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h84;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h85;

  // field positions
  localparam int COM_A_HI = 7;
  localparam int COM_A_LO = 6;
  localparam int COM_B_HI = 5;
  localparam int COM_B_LO = 4;
  localparam int WGM_LOW_HI = 1;
  localparam int WGM_LOW_LO = 0;
  localparam int WGM_HIGH_HI = 4;
  localparam int WGM_HIGH_LO = 3;
  localparam int PINS_PER_CHAN = 4;
  localparam int NUM_CHAN = 2;
  localparam int IRQ_OVF = 0;
  localparam int IRQ_MATCH_A = 1;
  localparam int IRQ_MATCH_B = 2;
  localparam int IRQ_BITS = 3;

  // writable masks and reset values
  localparam logic [7:0] MODE_CTRL_WMASK = 8'hf3;
  localparam logic [7:0] CTRL_SECOND_WMASK = 8'h18;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [2:0] IRQ_RESET = 3'h0;
  localparam logic [7:0] READ_ZERO = 8'h00;

  // counter values
  localparam logic [15:0] TOP_MAX = 16'hffff;
  localparam logic [15:0] TOP_8BIT = 16'h00ff;
  localparam logic [15:0] TOP_9BIT = 16'h01ff;
  localparam logic [15:0] TOP_10BIT = 16'h03ff;
  localparam logic [15:0] BOTTOM = 16'h0000;
  localparam logic [15:0] COUNT_STEP = 16'h0001;

  // compare-output mode codes
  localparam logic [1:0] COM_OFF = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR = 2'h2;
  localparam logic [1:0] COM_SET = 2'h3;

  typedef enum logic [1:0] {WAVE_NORMAL, WAVE_CTC, WAVE_FAST, WAVE_PHASE} tm16_wave_e;
  typedef enum logic [2:0] {TOP_SRC_MAX, TOP_SRC_8, TOP_SRC_9, TOP_SRC_10, TOP_SRC_CMPA,
                            TOP_SRC_CAPT} tm16_top_e;
  typedef enum logic [1:0] {EVT_IMMEDIATE, EVT_TOP, EVT_BOTTOM, EVT_MAX} tm16_evt_e;

  typedef struct packed {
    tm16_wave_e wave;
    tm16_top_e top_src;
    tm16_evt_e upd_at;
    tm16_evt_e ovf_at;
    logic top_bit;
  } tm16_mode_s;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } tm16_bus_s;

  function automatic tm16_mode_s tm16_decode_mode(input logic [3:0] m);
    tm16_mode_s d;
    d = '{WAVE_NORMAL, TOP_SRC_MAX, EVT_IMMEDIATE, EVT_MAX, m[3]};
    unique case (m)
      4'h0: d = '{WAVE_NORMAL, TOP_SRC_MAX, EVT_IMMEDIATE, EVT_MAX, m[3]};
      4'h1: d = '{WAVE_PHASE, TOP_SRC_8, EVT_TOP, EVT_BOTTOM, m[3]};
      4'h2: d = '{WAVE_PHASE, TOP_SRC_9, EVT_TOP, EVT_BOTTOM, m[3]};
      4'h3: d = '{WAVE_PHASE, TOP_SRC_10, EVT_TOP, EVT_BOTTOM, m[3]};
      4'h4: d = '{WAVE_CTC, TOP_SRC_CMPA, EVT_IMMEDIATE, EVT_MAX, m[3]};
      4'h5: d = '{WAVE_FAST, TOP_SRC_8, EVT_TOP, EVT_TOP, m[3]};
      4'h6: d = '{WAVE_FAST, TOP_SRC_9, EVT_TOP, EVT_TOP, m[3]};
      4'h7: d = '{WAVE_FAST, TOP_SRC_10, EVT_TOP, EVT_TOP, m[3]};
      4'h8: d = '{WAVE_PHASE, TOP_SRC_CAPT, EVT_BOTTOM, EVT_BOTTOM, m[3]};
      4'h9: d = '{WAVE_PHASE, TOP_SRC_CMPA, EVT_BOTTOM, EVT_BOTTOM, m[3]};
      4'ha: d = '{WAVE_PHASE, TOP_SRC_CAPT, EVT_TOP, EVT_BOTTOM, m[3]};
      4'hb: d = '{WAVE_PHASE, TOP_SRC_CMPA, EVT_TOP, EVT_BOTTOM, m[3]};
      4'hc: d = '{WAVE_CTC, TOP_SRC_CAPT, EVT_IMMEDIATE, EVT_MAX, m[3]};
      4'hd: d = '{WAVE_NORMAL, TOP_SRC_MAX, EVT_IMMEDIATE, EVT_MAX, m[3]};
      4'he: d = '{WAVE_FAST, TOP_SRC_CAPT, EVT_TOP, EVT_TOP, m[3]};
      4'hf: d = '{WAVE_FAST, TOP_SRC_CMPA, EVT_TOP, EVT_TOP, m[3]};
    endcase
    return d;
  endfunction

endpackage

// file: tm16_chan.sv
`timescale 1ns/1ps
module tm16_chan
  import tm16_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire tm16_pkg::tm16_mode_s i_mode,
  input wire logic [1:0] i_com,
  input wire logic i_is_chan_a,
  input wire logic i_tick,
  input wire logic i_match,
  input wire logic i_at_top,
  input wire logic i_down,
  output logic o_level,
  output logic o_connected
);
  logic pwm;
  logic toggle_ok;
  logic next_level;

  assign pwm = (i_mode.wave == WAVE_FAST) || (i_mode.wave == WAVE_PHASE);
  // toggle in pwm only on chan a with top mode bit set
  assign toggle_ok = !pwm || (i_mode.top_bit && i_is_chan_a);
  assign o_connected = (i_com != COM_OFF) && !((i_com == COM_TOGGLE) && !toggle_ok);

  always_comb
  begin
    next_level = o_level;
    if (i_tick && o_connected)
    begin
      unique case (i_mode.wave)
        WAVE_NORMAL, WAVE_CTC:
        begin
          if (i_match)
          begin
            unique case (i_com)
              COM_OFF: next_level = o_level;
              COM_TOGGLE: next_level = !o_level;
              COM_CLEAR: next_level = 1'b0;
              COM_SET: next_level = 1'b1;
            endcase
          end
        end
        WAVE_FAST:
        begin
          if (i_com == COM_TOGGLE)
          begin
            if (i_match)
              next_level = !o_level;
          end
          else if (i_at_top)
            next_level = (i_com == COM_CLEAR);
          else if (i_match)
            next_level = (i_com == COM_SET);
        end
        WAVE_PHASE:
        begin
          if (i_com == COM_TOGGLE)
          begin
            if (i_match)
              next_level = !o_level;
          end
          else if (i_match)
            next_level = (i_com == COM_CLEAR) ? i_down : !i_down;
        end
      endcase
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
      o_level <= 1'b0;
    else
      o_level <= next_level;
  end

  a_disc_level_hold: assert property (@(posedge i_mclk) disable iff (i_rst)
    !o_connected |=> (o_level == $past(o_level)))
    else $error("disconnected output changed");

  a_toggle_on_match: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_tick && i_match && !pwm && i_com == COM_TOGGLE) |=> (o_level != $past(o_level)))
    else $error("non-pwm toggle missed");

  a_fast_top_set: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_tick && i_at_top && i_match && i_mode.wave == WAVE_FAST && i_com == COM_CLEAR)
    |=> o_level)
    else $error("fast pwm top action lost to match");

  a_phase_up_clear: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_tick && i_match && i_mode.wave == WAVE_PHASE && i_com == COM_CLEAR)
    |=> (o_level == $past(i_down)))
    else $error("phase pwm match action wrong");

endmodule // tm16_chan

// file: tm16_wave_ctrl.sv
`timescale 1ns/1ps
// Operation
// - nonzero channel compare-mode field lets compare output override pin port function.
// - pin driver enabled only when direction bit and pin enable bit both set.
// - pin enable zero keeps pin disconnected regardless of compare mode.
// - non-pwm: 00 off, 01 toggle, 10 low, 11 high on match.
// - fast pwm: 10 clears on match, sets at top; 11 opposite.
// - pwm mode 01: off if top bit zero, else toggle chan a, b off.
// - fast pwm 10/11 with compare equal top: ignore match, do top action; 01 still toggles on match.
// - phase pwm: 10 clears on up match, sets on down; 11 opposite.
// - control bits 3 and 2 are reserved and read zero.
// - four-bit mode from two low bits here and two in second register.
// - modes 0, 4, 12: top max, compare a, capture; immediate; overflow at max.
// - phase modes 1-3 fixed tops, 10-11 capture/compare a; update top, flag bottom.
// - modes 8, 9 top capture/compare a; update and overflow at bottom.
// - fast modes 5-7 fixed tops, 14-15 capture/compare a; all at top.
// - dual-slope modes count up from zero to top, then down.
module tm16_wave_ctrl
  import tm16_pkg::*;
(
  input wire logic I_MCLK,
  input wire logic I_RST,
  input wire tm16_pkg::tm16_bus_s I_BUS,
  output logic [7:0] O_RDATA,
  input wire logic I_TICK,
  input wire logic [15:0] I_CMP_A,
  input wire logic [15:0] I_CMP_B,
  input wire logic [15:0] I_CAPTURE,
  input wire logic [7:0] I_PIN_DIR,
  output logic [7:0] O_PIN_OUT,
  output logic [7:0] O_PIN_OE_N,
  output logic [7:0] O_PIN_OVR,
  output logic [15:0] O_COUNT,
  output logic O_DOWN,
  output logic O_IRQ
);
  logic [7:0] mode_ctrl;
  logic [7:0] ctrl_second;
  logic [7:0] pin_en;
  logic [IRQ_BITS-1:0] irq_status;
  logic [IRQ_BITS-1:0] irq_mask;
  logic [IRQ_BITS-1:0] events;
  logic [3:0] wave_mode;
  tm16_mode_s mode;
  logic [15:0] cnt;
  logic down;
  logic [15:0] top;
  logic dual;
  logic hit_top;
  logic hit_bottom;
  logic hit_max;
  logic [15:0] cmp_buf [NUM_CHAN];
  logic [15:0] cmp_eff [NUM_CHAN];
  logic [1:0] com [NUM_CHAN];
  logic match [NUM_CHAN];
  logic level [NUM_CHAN];
  logic connected [NUM_CHAN];
  logic wr_mode;
  logic wr_second;
  logic wr_pin;
  logic wr_mask;
  logic rd_status;
  logic [7:0] next_rdata;

  function automatic logic evt_hit(input tm16_evt_e e, input logic t, input logic b,
                                   input logic m);
    logic r;
    r = 1'b0;
    unique case (e)
      EVT_IMMEDIATE: r = 1'b1;
      EVT_TOP: r = t;
      EVT_BOTTOM: r = b;
      EVT_MAX: r = m;
    endcase
    return r;
  endfunction

  // register bus decode
  assign wr_mode = I_BUS.wr && (I_BUS.addr == ADDR_MODE_CTRL);
  assign wr_second = I_BUS.wr && (I_BUS.addr == ADDR_CTRL_SECOND);
  assign wr_pin = I_BUS.wr && (I_BUS.addr == ADDR_PIN_EN);
  assign wr_mask = I_BUS.wr && (I_BUS.addr == ADDR_IRQ_MASK);
  assign rd_status = I_BUS.rd && (I_BUS.addr == ADDR_IRQ_STATUS);

  always_ff @(posedge I_MCLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      mode_ctrl <= REG_RESET;
      ctrl_second <= REG_RESET;
      pin_en <= REG_RESET;
      irq_mask <= IRQ_RESET;
    end
    else
    begin
      if (wr_mode)
        mode_ctrl <= I_BUS.wdata & MODE_CTRL_WMASK;
      if (wr_second)
        ctrl_second <= I_BUS.wdata & CTRL_SECOND_WMASK;
      if (wr_pin)
        pin_en <= I_BUS.wdata;
      if (wr_mask)
        irq_mask <= I_BUS.wdata[IRQ_BITS-1:0];
    end
  end

  always_comb
  begin
    next_rdata = READ_ZERO;
    if (I_BUS.rd)
    begin
      if (I_BUS.addr == ADDR_MODE_CTRL)
        next_rdata = mode_ctrl;
      else if (I_BUS.addr == ADDR_CTRL_SECOND)
        next_rdata = ctrl_second;
      else if (I_BUS.addr == ADDR_PIN_EN)
        next_rdata = pin_en;
      else if (I_BUS.addr == ADDR_IRQ_STATUS)
        next_rdata = {5'h00, irq_status};
      else if (I_BUS.addr == ADDR_IRQ_MASK)
        next_rdata = {5'h00, irq_mask};
    end
  end

  always_ff @(posedge I_MCLK or posedge I_RST)
  begin
    if (I_RST)
      O_RDATA <= READ_ZERO;
    else
      O_RDATA <= next_rdata;
  end

  // mode decode; reserved mode 13 behaves as normal
  assign wave_mode = {ctrl_second[WGM_HIGH_HI:WGM_HIGH_LO],
                      mode_ctrl[WGM_LOW_HI:WGM_LOW_LO]};
  assign mode = tm16_decode_mode(wave_mode);
  assign dual = (mode.wave == WAVE_PHASE);

  always_comb
  begin
    top = TOP_MAX;
    unique case (mode.top_src)
      TOP_SRC_MAX: top = TOP_MAX;
      TOP_SRC_8: top = TOP_8BIT;
      TOP_SRC_9: top = TOP_9BIT;
      TOP_SRC_10: top = TOP_10BIT;
      TOP_SRC_CMPA: top = cmp_eff[0];
      TOP_SRC_CAPT: top = I_CAPTURE;
    endcase
  end

  assign hit_top = I_TICK && (cnt == top);
  assign hit_bottom = I_TICK && down && (cnt == BOTTOM);
  assign hit_max = I_TICK && (cnt == TOP_MAX);

  // counter sequence
  always_ff @(posedge I_MCLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      cnt <= BOTTOM;
      down <= 1'b0;
    end
    else if (I_TICK)
    begin
      if (dual)
      begin
        if (!down)
        begin
          if (cnt >= top)
          begin
            down <= 1'b1;
            if (cnt != BOTTOM)
              cnt <= cnt - COUNT_STEP;
          end
          else
            cnt <= cnt + COUNT_STEP;
        end
        else if (cnt == BOTTOM)
        begin
          down <= 1'b0;
          cnt <= cnt + COUNT_STEP;
        end
        else
          cnt <= cnt - COUNT_STEP;
      end
      else
      begin
        down <= 1'b0;
        if ((mode.wave != WAVE_NORMAL) && (cnt >= top))
          cnt <= BOTTOM;
        else
          cnt <= cnt + COUNT_STEP;
      end
    end
  end

  assign cmp_buf[0] = I_CMP_A;
  assign cmp_buf[1] = I_CMP_B;
  assign com[0] = mode_ctrl[COM_A_HI:COM_A_LO];
  assign com[1] = mode_ctrl[COM_B_HI:COM_B_LO];

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CHAN; ch++)
    begin : g_chan
      // compare double buffer
      always_ff @(posedge I_MCLK or posedge I_RST)
      begin
        if (I_RST)
          cmp_eff[ch] <= BOTTOM;
        else if (evt_hit(mode.upd_at, hit_top, hit_bottom, hit_max))
          cmp_eff[ch] <= cmp_buf[ch];
      end

      assign match[ch] = I_TICK && (cnt == cmp_eff[ch]);

      tm16_chan u_chan (
        .i_mclk(I_MCLK),
        .i_rst(I_RST),
        .i_mode(mode),
        .i_com(com[ch]),
        .i_is_chan_a(ch == 0),
        .i_tick(I_TICK),
        .i_match(match[ch]),
        .i_at_top(hit_top),
        .i_down(down),
        .o_level(level[ch]),
        .o_connected(connected[ch])
      );

      genvar p;
      for (p = 0; p < PINS_PER_CHAN; p++)
      begin : g_pin
        localparam int IDX = ch * PINS_PER_CHAN + p;
        assign O_PIN_OVR[IDX] = connected[ch] && pin_en[IDX];
        assign O_PIN_OE_N[IDX] = !(O_PIN_OVR[IDX] && I_PIN_DIR[IDX]);
        assign O_PIN_OUT[IDX] = level[ch];
      end
    end
  endgenerate

  // interrupt status, set wins over read clear
  assign events[IRQ_OVF] = evt_hit(mode.ovf_at, hit_top, hit_bottom, hit_max);
  assign events[IRQ_MATCH_A] = match[0];
  assign events[IRQ_MATCH_B] = match[1];

  always_ff @(posedge I_MCLK or posedge I_RST)
  begin
    if (I_RST)
      irq_status <= IRQ_RESET;
    else if (rd_status)
      irq_status <= events;
    else
      irq_status <= irq_status | events;
  end

  assign O_IRQ = |(irq_status & irq_mask);
  assign O_COUNT = cnt;
  assign O_DOWN = down;

  a_reserved_read_zero: assert property (@(posedge I_MCLK) disable iff (I_RST)
    (I_BUS.rd && I_BUS.addr == ADDR_MODE_CTRL) |=> (O_RDATA[3:2] == 2'h0))
    else $error("reserved control bits read nonzero");

  a_pin_driver_gate: assert property (@(posedge I_MCLK) disable iff (I_RST)
    !O_PIN_OE_N[0] |-> (I_PIN_DIR[0] && pin_en[0] && mode_ctrl[COM_A_HI:COM_A_LO] != COM_OFF))
    else $error("pin driven without enables");

  a_mode_fixed_top: assert property (@(posedge I_MCLK) disable iff (I_RST)
    (wave_mode == 4'h3) |-> (top == TOP_10BIT && dual))
    else $error("mode 3 top wrong");

  a_dual_turn_down: assert property (@(posedge I_MCLK) disable iff (I_RST)
    (dual && I_TICK && !down && cnt == top && top != BOTTOM)
    |=> (down && cnt == $past(cnt) - COUNT_STEP))
    else $error("dual slope did not turn at top");

  a_ovf_at_bottom: assert property (@(posedge I_MCLK) disable iff (I_RST)
    (wave_mode == 4'h8 && hit_bottom) |=> irq_status[IRQ_OVF])
    else $error("overflow not flagged at bottom");

  a_fast_top_update: assert property (@(posedge I_MCLK) disable iff (I_RST)
    (mode.wave == WAVE_FAST && !hit_top) |=> (cmp_eff[1] == $past(cmp_eff[1])))
    else $error("fast pwm compare updated off top");

endmodule // tm16_wave_ctrl

// file: tm16_testbench.sv
`timescale 1ns/1ps
module testbench;
  import tm16_pkg::*;
  logic I_MCLK;
  logic I_RST;
  logic I_TICK;
  tm16_bus_s bus;
  logic [15:0] cmp_a, cmp_b, capt, count, mx;
  logic [7:0] pin_dir, rdata, pin_out, pin_oe_n, pin_ovr, d;
  logic down, irq;
  int error_cnt, checked;

  tm16_wave_ctrl i_dut (.I_MCLK(I_MCLK), .I_RST(I_RST), .I_BUS(bus), .O_RDATA(rdata),
    .I_TICK(I_TICK), .I_CMP_A(cmp_a), .I_CMP_B(cmp_b), .I_CAPTURE(capt),
    .I_PIN_DIR(pin_dir), .O_PIN_OUT(pin_out), .O_PIN_OE_N(pin_oe_n), .O_PIN_OVR(pin_ovr),
    .O_COUNT(count), .O_DOWN(down), .O_IRQ(irq));

  initial
  begin
    I_MCLK = 1'b0;
    forever #5 I_MCLK = ~I_MCLK;
  end

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one-cycle bus strobes, read data sampled in the cycle after
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge I_MCLK);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge I_MCLK);
    bus.wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(posedge I_MCLK);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge I_MCLK);
    bus.rd <= 1'b0;
    #1;
    q = rdata;
  endtask

  task automatic set_mode(input logic [3:0] m, input logic [3:0] coms); // no mode 13
    wr(ADDR_MODE_CTRL, {coms, 2'h0, m[1:0]});
    wr(ADDR_CTRL_SECOND, {3'h0, m[3:2], 3'h0});
  endtask

  // n timer ticks back to back, with a per-cycle check chosen by kind
  task automatic run(input int n, input int kind);
    logic [15:0] prev;
    @(posedge I_MCLK);
    I_TICK <= 1'b1;
    for (int i = 0; i < n; i++)
    begin
      prev = count;
      @(posedge I_MCLK);
      if (i == n - 1)
        I_TICK <= 1'b0;
      #1;
      case (kind)
        1: chk(pin_out, {{4{count > 16'h4}}, {4{count <= 16'h4}}});
        2: chk(pin_out[3:0], 4'hf);
        3: chk({count == prev + 16'h1 || count + 16'h1 == prev, down, pin_out[7:4]},
               {1'b1, count < prev,
                {4{(count < prev) ? count < 16'h4 : count <= 16'h4}}});
        4: if (count > mx) mx = count;
        default: ;
      endcase
    end
  endtask

  task automatic t_reset();
    logic [7:0] addrs [5];
    addrs = '{ADDR_MODE_CTRL, ADDR_CTRL_SECOND, ADDR_PIN_EN, ADDR_IRQ_STATUS, ADDR_IRQ_MASK};
    foreach (addrs[i])
    begin
      rd(addrs[i], d);
      chk(d, 8'h00);
    end
    chk({pin_oe_n, pin_ovr}, 16'hff00);
    chk(irq, 1'b0);
    chk(count, 16'h0);
    chk({down, pin_out}, 9'h000);
  endtask

  task automatic t_regs();
    wr(ADDR_MODE_CTRL, 8'hff);
    rd(ADDR_MODE_CTRL, d);
    chk(d, 8'hf3);
    wr(ADDR_CTRL_SECOND, 8'hff);
    rd(ADDR_CTRL_SECOND, d);
    chk(d, 8'h18);
    rd(8'h90, d);
    chk(d, 8'h00);
    wr(ADDR_IRQ_STATUS, 8'hff);
    rd(ADDR_IRQ_STATUS, d);
    chk(d, 8'h00);
    set_mode(4'h0, 4'h0);
  endtask

  task automatic t_pins();
    wr(ADDR_MODE_CTRL, 8'h40);
    wr(ADDR_PIN_EN, 8'h05);
    #1;
    chk(pin_ovr, 8'h05);
    chk(pin_oe_n, 8'hfe);
    wr(ADDR_PIN_EN, 8'hf0);
    #1;
    chk(pin_ovr, 8'h00);
    wr(ADDR_MODE_CTRL, 8'h10);
    #1;
    chk(pin_ovr, 8'hf0);
    chk(pin_oe_n, 8'hff);
  endtask

  // clear-on-match with top 3: one match per four ticks
  task automatic t_ctc();
    logic [1:0] codes [4];
    logic lv [4];
    codes = '{2'h3, 2'h2, 2'h1, 2'h1};
    lv = '{1'b1, 1'b0, 1'b1, 1'b0};
    wr(ADDR_PIN_EN, 8'h0f);
    pin_dir <= 8'hff;
    cmp_a <= 16'h3;
    wr(ADDR_IRQ_MASK, 8'h02);
    set_mode(4'h4, 4'h0);
    foreach (codes[i])
    begin
      wr(ADDR_MODE_CTRL, {codes[i], 6'h0});
      run(4, 0);
      chk(pin_out[3:0], {4{lv[i]}});
    end
    chk(count, 16'h0);
    wr(ADDR_MODE_CTRL, 8'h00);
    #1;
    chk(pin_ovr, 8'h00);
    chk(irq, 1'b1);
    wr(ADDR_IRQ_MASK, 8'h00);
    #1;
    chk(irq, 1'b0);
    wr(ADDR_IRQ_MASK, 8'h02);
    #1;
    chk(irq, 1'b1);
    rd(ADDR_IRQ_STATUS, d);
    chk({irq, d}, 9'h002);
    rd(ADDR_IRQ_STATUS, d);
    chk(d, 8'h00);
  endtask

  task automatic t_fast();
    wr(ADDR_PIN_EN, 8'hff);
    cmp_a <= 16'h4;
    set_mode(4'he, 4'hb);
    rd(ADDR_IRQ_STATUS, d);
    run(25, 0);
    run(20, 1);
    rd(ADDR_IRQ_STATUS, d);
    chk(d, 8'h07);
    set_mode(4'hf, 4'h9);
    cmp_a <= 16'h9;
    run(25, 0);
    run(20, 2);
    chk(pin_ovr[7:4], 4'h0);
  endtask

  task automatic t_phase(input logic [3:0] m);
    set_mode(m, 4'h2);
    rd(ADDR_IRQ_STATUS, d);
    run(40, 0);
    run(40, 3);
    chk(pin_ovr, 8'hf0);
    rd(ADDR_IRQ_STATUS, d);
    chk(d[IRQ_OVF], 1'b1);
  endtask

  task automatic t_tops();
    logic [3:0] ms [6];
    ms = '{4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7};
    foreach (ms[i])
    begin
      set_mode(ms[i], 4'h0);
      mx = 16'h0;
      run(2100, 4);
      chk(mx, 16'hffff >> (9 - ms[i][1:0]));
    end
    set_mode(4'hc, 4'h0);
    mx = 16'h0;
    run(30, 4);
    chk(mx, capt);
  endtask

  // reset again in mid-run, after counter, levels and registers have moved; the last status read has already cleared the flags
  task automatic t_mid_reset();
    @(posedge I_MCLK);
    I_RST <= 1'b1;
    repeat (2) @(posedge I_MCLK);
    I_RST <= 1'b0;
    t_reset();
  endtask

  initial
  begin
    #300000;
    error_cnt++;
    final_report();
  end

  initial
  begin
    I_RST = 1'b1;
    I_TICK = 1'b0;
    bus = '0;
    cmp_a = 16'h0;
    cmp_b = 16'h4;
    capt = 16'h9;
    pin_dir = 8'h03;
    error_cnt = 0;
    checked = 0;
    repeat (12) @(posedge I_MCLK);
    I_RST <= 1'b0;
    t_reset();
    t_regs();
    t_pins();
    t_ctc();
    t_fast();
    t_phase(4'hb);
    t_phase(4'h9);
    t_phase(4'h8);
    t_phase(4'ha);
    t_mid_reset();
    t_tops();
    final_report();
  end
endmodule // testbench
